//--- rrs_alu.sv
/*
 * Decode and execute stage for rotate right, rotate through carry and reverse subtract.
 * Assumes the register file answers read indices in the same cycle and the
 * condition check and if-then state are supplied by the core front end.
 */
`timescale 1ns/1ps
`default_nettype none
module rrs_alu
    import rrs_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic instr_valid_i,
    input wire logic instr_is_long_i,
    input wire logic [31:0] instr_i,
    input wire logic cond_pass_i,
    input wire logic in_if_then_block_i,
    input wire logic [FLAG_W-1:0] program_status_flags_i,
    input wire logic [DATA_W-1:0] first_operand_val_i,
    input wire logic [DATA_W-1:0] second_operand_val_i,
    output logic [REG_W-1:0] first_operand_reg_o,
    output logic [REG_W-1:0] second_operand_reg_o,
    output logic done_o,
    output logic recognised_o,
    output logic unpredictable_o,
    output logic wr_en_o,
    output logic [REG_W-1:0] wr_reg_o,
    output logic [DATA_W-1:0] wr_data_o,
    output logic flags_we_o,
    output logic [FLAG_W-1:0] program_status_flags_o
);
    if (DATA_W != WORD_W) begin : g_width_check
        $error("rrs_alu supports only a 32-bit data path");
    end

    // ==========================================================
    // modified constant expansion
    // ==========================================================
    function automatic logic [WORD_W-1:0] modified_constant_expand(input logic [11:0] f);
        logic [WORD_W-1:0] base;
        logic [2*WORD_W-1:0] dbl;
        base = '0;
        dbl = '0;
        if (f[11:10] == 2'b00) begin
            case (f[9:8])
                2'b00: base = {24'h000000, f[7:0]};
                2'b01: base = {8'h00, f[7:0], 8'h00, f[7:0]};
                2'b10: base = {f[7:0], 8'h00, f[7:0], 8'h00};
                default: base = {f[7:0], f[7:0], f[7:0], f[7:0]};
            endcase
        end else begin
            base = {24'h000000, 1'b1, f[6:0]};
            dbl = {base, base} >> f[11:7];
            base = dbl[WORD_W-1:0];
        end
        return base;
    endfunction

    function automatic logic bad_reg(input logic [3:0] r);
        return (r == REG_SP) || (r == REG_PC);
    endfunction

    // ==========================================================
    // decode
    // ==========================================================
    logic [15:0] hw1;
    logic [15:0] hw2;
    op_t op;
    logic [REG_W-1:0] dst;
    logic setflags;
    logic unpred;
    logic [4:0] imm5;
    logic [WORD_W-1:0] imm;

    assign hw1 = instr_i[31:16];
    assign hw2 = instr_i[15:0];
    assign imm5 = {hw2[14:12], hw2[7:6]};

    always_comb begin
        op = OP_NONE;
        dst = '0;
        setflags = 1'b0;
        unpred = 1'b0;
        imm = '0;
        first_operand_reg_o = '0;
        second_operand_reg_o = '0;
        if (!instr_is_long_i) begin
            if (hw2[15:6] == SHORT_ROT_REG) begin
                op = OP_ROT_REG;
                dst = {1'b0, hw2[2:0]};
                first_operand_reg_o = {1'b0, hw2[2:0]};
                second_operand_reg_o = {1'b0, hw2[5:3]};
                setflags = !in_if_then_block_i;
            end else if (hw2[15:6] == SHORT_REV_SUB) begin
                op = OP_REV_SUB;
                dst = {1'b0, hw2[2:0]};
                first_operand_reg_o = {1'b0, hw2[5:3]};
                imm = '0;
                setflags = !in_if_then_block_i;
            end
        end else if ((hw1 & LONG_ROT_IMM_MASK) == LONG_ROT_IMM_VAL
                && (hw2 & LONG_ROT_IMM_H2_MASK) == LONG_ROT_IMM_H2_VAL) begin
            op = (imm5 == 5'h00) ? OP_ROT_CARRY : OP_ROT_IMM;
            dst = hw2[11:8];
            first_operand_reg_o = hw2[3:0];
            setflags = hw1[S_BIT];
            unpred = bad_reg(hw2[11:8]) || bad_reg(hw2[3:0]);
        end else if ((hw1 & LONG_ROT_REG_MASK) == LONG_ROT_REG_VAL
                && (hw2 & LONG_ROT_REG_H2_MASK) == LONG_ROT_REG_H2_VAL) begin
            op = OP_ROT_REG;
            dst = hw2[11:8];
            first_operand_reg_o = hw1[3:0];
            second_operand_reg_o = hw2[3:0];
            setflags = hw1[S_BIT];
            unpred = bad_reg(hw2[11:8]) || bad_reg(hw1[3:0]) || bad_reg(hw2[3:0]);
        end else if ((hw1 & LONG_REV_SUB_MASK) == LONG_REV_SUB_VAL
                && (hw2 & LONG_REV_SUB_H2_MASK) == LONG_REV_SUB_H2_VAL) begin
            op = OP_REV_SUB;
            dst = hw2[11:8];
            first_operand_reg_o = hw1[3:0];
            imm = modified_constant_expand({hw1[I_BIT], hw2[14:12], hw2[7:0]});
            setflags = hw1[S_BIT];
            unpred = bad_reg(hw2[11:8]) || bad_reg(hw1[3:0]);
        end
    end

    // ==========================================================
    // execute unit
    // ==========================================================
    rrs_exec_if ex ();

    always_comb begin
        ex.op = op;
        ex.operand = first_operand_val_i;
        ex.imm = imm;
        ex.carry_in = program_status_flags_i[FLAG_C];
        if (op == OP_ROT_REG) begin
            ex.amount = second_operand_val_i[7:0];
        end else if (op == OP_ROT_IMM) begin
            ex.amount = {3'b000, imm5};
        end else begin
            ex.amount = 8'h00;
        end
    end

    rrs_unit u_unit (
        .ex(ex.unit)
    );

    // ==========================================================
    // flags
    // ==========================================================
    logic [FLAG_W-1:0] flags_nxt;
    logic go;

    assign go = instr_valid_i && (op != OP_NONE) && cond_pass_i && !unpred;

    always_comb begin
        flags_nxt = program_status_flags_i;
        flags_nxt[FLAG_N] = ex.result[WORD_W-1];
        flags_nxt[FLAG_Z] = (ex.result == '0);
        flags_nxt[FLAG_C] = ex.carry;
        if (op == OP_REV_SUB) begin
            flags_nxt[FLAG_V] = ex.overflow;
        end
    end

    // ==========================================================
    // result registers
    // ==========================================================
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_o <= 1'b0;
            recognised_o <= 1'b0;
            unpredictable_o <= 1'b0;
        end else begin
            done_o <= instr_valid_i;
            recognised_o <= instr_valid_i && (op != OP_NONE);
            unpredictable_o <= instr_valid_i && (op != OP_NONE) && unpred;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_en_o <= 1'b0;
            wr_reg_o <= '0;
            wr_data_o <= '0;
        end else begin
            wr_en_o <= go;
            if (go) begin
                wr_reg_o <= dst;
                wr_data_o <= ex.result;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_we_o <= 1'b0;
            program_status_flags_o <= FLAGS_RST;
        end else begin
            flags_we_o <= go && setflags;
            if (go && setflags) begin
                program_status_flags_o <= flags_nxt;
            end
        end
    end
endmodule
`default_nettype wire

//--- rrs_pkg.sv
/*
 * Constants, opcode patterns and types for the rotate / reverse subtract datapath.
 * Assumes a 32-bit core with sixteen registers and packed N Z C V flags.
 */
// What this block does
// - nothing is written, neither register nor flag, unless the condition check passes.
// - immediate rotate writes the operand rotated right by the decoded amount, carry from the rotation.
// - every bit leaving bit 0 during a rotate re-enters at bit 31.
// - register rotate uses only the unsigned low eight bits of the count register.
// - short register rotate has the count register in bits 5..3 and destination/operand in bits 2..0.
// - short register rotate writes flags only outside an if-then block.
// - long register rotate names destination, operand and count, and its S bit selects flag writes.
// - with flag writes a rotate sets N from bit 31, Z on zero, C from shift carry, V unchanged.
// - rotate through carry shifts right by one and puts the old carry into bit 31.
// - rotate through carry with flag writes makes the old bit 0 the new carry.
// - rotate through carry has an S bit and treats register 13 or 15 as unpredictable.
// - immediate reverse subtract writes the constant minus the first operand.
// - short reverse subtract uses a zero constant and writes flags only outside an if-then block.
// - long reverse subtract expands a 12-bit field, has an S bit, and treats 13 or 15 as unpredictable.
// - reverse subtract computes inverted operand plus constant plus one and sets N Z C V from it.
// - immediate rotate amount is 1 to 31; a zero amount field means rotate through carry.
package rrs_pkg;
    localparam int WORD_W = 32;
    localparam int REG_W = 4;
    localparam int FLAG_W = 4;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [3:0] REG_SP = 4'hD;
    localparam logic [3:0] REG_PC = 4'hF;
    // short forms: bits 15..6 of the halfword
    localparam logic [9:0] SHORT_ROT_REG = 10'h107;
    localparam logic [9:0] SHORT_REV_SUB = 10'h109;
    // long forms: first halfword with S and register fields masked
    localparam logic [15:0] LONG_ROT_IMM_MASK = 16'hFFEF;
    localparam logic [15:0] LONG_ROT_IMM_VAL = 16'hEA4F;
    localparam logic [15:0] LONG_ROT_IMM_H2_MASK = 16'h8030;
    localparam logic [15:0] LONG_ROT_IMM_H2_VAL = 16'h0030;
    localparam logic [15:0] LONG_ROT_REG_MASK = 16'hFFE0;
    localparam logic [15:0] LONG_ROT_REG_VAL = 16'hFA60;
    localparam logic [15:0] LONG_ROT_REG_H2_MASK = 16'hF0F0;
    localparam logic [15:0] LONG_ROT_REG_H2_VAL = 16'hF000;
    localparam logic [15:0] LONG_REV_SUB_MASK = 16'hFBE0;
    localparam logic [15:0] LONG_REV_SUB_VAL = 16'hF1C0;
    localparam logic [15:0] LONG_REV_SUB_H2_MASK = 16'h8000;
    localparam logic [15:0] LONG_REV_SUB_H2_VAL = 16'h0000;
    localparam int S_BIT = 4;
    localparam int I_BIT = 10;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_ROT_IMM = 3'b001,
        OP_ROT_REG = 3'b010,
        OP_ROT_CARRY = 3'b011,
        OP_REV_SUB = 3'b100
    } op_t;
endpackage

//--- rrs_exec_if.sv
/*
 * Carrier between the decode/control module and the arithmetic unit.
 * Assumes both ends sit in the same clock domain; the unit is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
interface rrs_exec_if;
    import rrs_pkg::*;
    op_t op;
    logic [WORD_W-1:0] operand;
    logic [7:0] amount;
    logic [WORD_W-1:0] imm;
    logic carry_in;
    logic [WORD_W-1:0] result;
    logic carry;
    logic overflow;

    modport unit (
        input op,
        input operand,
        input amount,
        input imm,
        input carry_in,
        output result,
        output carry,
        output overflow
    );
    modport ctrl (
        output op,
        output operand,
        output amount,
        output imm,
        output carry_in,
        input result,
        input carry,
        input overflow
    );
endinterface
`default_nettype wire

//--- rrs_unit.sv
/*
 * Combinational rotate, rotate-through-carry and reverse subtract unit.
 * Assumes the controller holds its inputs stable for the cycle it samples the outputs.
 */
`timescale 1ns/1ps
`default_nettype none
module rrs_unit
    import rrs_pkg::*;
(
    rrs_exec_if.unit ex
);
    // ==========================================================
    // rotate and add
    // ==========================================================
    logic [2*WORD_W-1:0] dbl;
    logic [WORD_W:0] sum;
    logic [WORD_W-1:0] rot;

    always_comb begin
        dbl = {ex.operand, ex.operand} >> ex.amount[4:0];
        rot = dbl[WORD_W-1:0];
        sum = {1'b0, ~ex.operand} + {1'b0, ex.imm} + {{WORD_W{1'b0}}, 1'b1};
        ex.result = ex.operand;
        ex.carry = ex.carry_in;
        ex.overflow = 1'b0;
        case (ex.op)
            OP_ROT_IMM, OP_ROT_REG: begin
                if (ex.amount != 8'h00) begin
                    ex.result = rot;
                    ex.carry = rot[WORD_W-1];
                end
            end
            OP_ROT_CARRY: begin
                ex.result = {ex.carry_in, ex.operand[WORD_W-1:1]};
                ex.carry = ex.operand[0];
            end
            OP_REV_SUB: begin
                ex.result = sum[WORD_W-1:0];
                ex.carry = sum[WORD_W];
                ex.overflow = (ex.operand[WORD_W-1] != ex.imm[WORD_W-1])
                    && (sum[WORD_W-1] != ex.imm[WORD_W-1]);
            end
            default: begin
                ex.result = ex.operand;
            end
        endcase
    end
endmodule
`default_nettype wire

//--- rrs_alu_checker.sv
/*
 * Port checker for rrs_alu, attached by bind.
 * Assumes one clock, reset high, one-cycle answer to each instruction.
 */
`timescale 1ns/1ps
`default_nettype none
module rrs_alu_checker
    import rrs_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic instr_valid_i,
    input wire logic instr_is_long_i,
    input wire logic [31:0] instr_i,
    input wire logic cond_pass_i,
    input wire logic in_if_then_block_i,
    input wire logic [FLAG_W-1:0] program_status_flags_i,
    input wire logic [DATA_W-1:0] first_operand_val_i,
    input wire logic [DATA_W-1:0] second_operand_val_i,
    input wire logic [REG_W-1:0] first_operand_reg_o,
    input wire logic [REG_W-1:0] second_operand_reg_o,
    input wire logic wr_en_o,
    input wire logic [REG_W-1:0] wr_reg_o,
    input wire logic [DATA_W-1:0] wr_data_o,
    input wire logic flags_we_o,
    input wire logic unpredictable_o,
    input wire logic [FLAG_W-1:0] program_status_flags_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    function automatic logic [31:0] rot32(logic [31:0] v, logic [7:0] n);
        return (v >> n[4:0]) | (v << (6'h20 - {1'b0, n[4:0]}));
    endfunction
    // ==========================================
    // short forms taken
    sequence short_rot_go;
        instr_valid_i && cond_pass_i && !instr_is_long_i && instr_i[15:6] == SHORT_ROT_REG;
    endsequence
    sequence short_sub_go;
        instr_valid_i && cond_pass_i && !instr_is_long_i && instr_i[15:6] == SHORT_REV_SUB;
    endsequence
    // ==========================================
    // assertions
    cond_fail_a: assert property (instr_valid_i && !cond_pass_i |=> !wr_en_o && !flags_we_o)
        else $error("write despite failed condition");
    short_idx_a: assert property (!instr_is_long_i && instr_i[15:6] == SHORT_ROT_REG
        |-> first_operand_reg_o == {1'b0, instr_i[2:0]} && second_operand_reg_o == {1'b0, instr_i[5:3]})
        else $error("short rotate read index wrong");
    short_dest_a: assert property (short_rot_go |=> wr_en_o && wr_reg_o == {1'b0, $past(instr_i[2:0])})
        else $error("short rotate destination wrong");
    rot_value_a: assert property (short_rot_go
        |=> wr_data_o == rot32($past(first_operand_val_i), $past(second_operand_val_i[7:0])))
        else $error("rotate result wrong");
    block_flags_a: assert property (instr_valid_i && !instr_is_long_i && in_if_then_block_i |=> !flags_we_o)
        else $error("flags written inside if-then block");
    rot_flags_a: assert property (short_rot_go ##0 !in_if_then_block_i |=> flags_we_o
        && program_status_flags_o[FLAG_N] == wr_data_o[31] && program_status_flags_o[FLAG_Z] == (wr_data_o == 32'h0)
        && program_status_flags_o[FLAG_V] == $past(program_status_flags_i[FLAG_V]))
        else $error("rotate flags wrong");
    rot_carry_a: assert property (short_rot_go ##0 !in_if_then_block_i |=> program_status_flags_o[FLAG_C] ==
        (($past(second_operand_val_i[7:0]) == 8'h00) ? $past(program_status_flags_i[FLAG_C]) : wr_data_o[31]))
        else $error("rotate carry wrong");
    sub_neg_a: assert property (short_sub_go |=> wr_en_o && wr_data_o == ~$past(first_operand_val_i) + 32'h1)
        else $error("negate result wrong");
    unpred_quiet_a: assert property (unpredictable_o |-> !wr_en_o && !flags_we_o)
        else $error("write on unpredictable form");
endmodule
bind rrs_alu rrs_alu_checker #(.DATA_W(DATA_W)) checker_i (.*);
`default_nettype wire

//--- rrs_regfile_model.sv
/*
 * Register file and flag holder standing in front of the block.
 * Assumes reads are combinational and commits land at the edge after the pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module rrs_regfile_model (
    input wire logic clk_i,
    input wire logic ld_en_i,
    input wire logic [3:0] ld_idx_i,
    input wire logic [31:0] ld_val_i,
    input wire logic [3:0] ld_flags_i,
    input wire logic [3:0] rd_a_i,
    input wire logic [3:0] rd_b_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_reg_i,
    input wire logic [31:0] wr_data_i,
    input wire logic flags_we_i,
    input wire logic [3:0] flags_new_i,
    output logic [31:0] val_a_o,
    output logic [31:0] val_b_o,
    output logic [3:0] flags_o
);
    logic [31:0] regs [16];
    initial begin
        foreach (regs[i]) regs[i] = 32'h0;
        flags_o = 4'h0;
    end
    // ==========================================
    // commit and preload
    always @(posedge clk_i) begin
        if (wr_en_i) regs[wr_reg_i] <= wr_data_i;
        if (flags_we_i) flags_o <= flags_new_i;
        if (ld_en_i) begin
            regs[ld_idx_i] <= ld_val_i;
            flags_o <= ld_flags_i;
        end
    end
    assign val_a_o = regs[rd_a_i];
    assign val_b_o = regs[rd_b_i];
endmodule
`default_nettype wire

//--- rotate_reverse_subtract_alu_bench.sv
/*
 * Directed bench for rrs_alu with a register file model.
 * Assumes a 200 MHz clock and one instruction every other cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module rotate_reverse_subtract_alu_bench;
    import rrs_pkg::*;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, instr_valid_i = 1'b0, instr_is_long_i = 1'b0;
    logic cond_pass_i = 1'b0, in_if_then_block_i = 1'b0, ld_en = 1'b0;
    logic [31:0] instr_i = 32'h0, ld_val = 32'h0, first_operand_val_i, second_operand_val_i, wr_data_o;
    logic [3:0] ld_idx = 4'h0, ld_flags = 4'h0, program_status_flags_i, program_status_flags_o;
    logic [3:0] first_operand_reg_o, second_operand_reg_o, wr_reg_o;
    logic done_o, recognised_o, unpredictable_o, wr_en_o, flags_we_o;
    int fails = 0, checked = 0, cycles = 0;
    rrs_alu DUT (.*);
    rrs_regfile_model partner (.clk_i(sys_clk_i), .ld_en_i(ld_en), .ld_idx_i(ld_idx),
        .ld_val_i(ld_val), .ld_flags_i(ld_flags), .rd_a_i(first_operand_reg_o),
        .rd_b_i(second_operand_reg_o), .wr_en_i(wr_en_o), .wr_reg_i(wr_reg_o), .wr_data_i(wr_data_o),
        .flags_we_i(flags_we_o), .flags_new_i(program_status_flags_o), .val_a_o(first_operand_val_i),
        .val_b_o(second_operand_val_i), .flags_o(program_status_flags_i));
    always #2.5 sys_clk_i = ~sys_clk_i;
    // ==========================================
    // shared tasks
    task automatic report_and_stop();
        if (fails == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic load(input logic [3:0] idx, input logic [31:0] val, input logic [3:0] fl);
        @(posedge sys_clk_i);
        ld_en <= 1'b1;
        ld_idx <= idx;
        ld_val <= val;
        ld_flags <= fl;
        @(posedge sys_clk_i);
        ld_en <= 1'b0;
    endtask
    task automatic exec(input logic lng, input logic [31:0] ins, input logic cnd, input logic blk,
        input logic we, input logic [3:0] rd, input logic [31:0] dat, input logic fwe, input logic [3:0] fl);
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b1;
        instr_is_long_i <= lng;
        instr_i <= ins;
        cond_pass_i <= cnd;
        in_if_then_block_i <= blk;
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b0;
        #1;
        check(done_o, 1'b1, "done");
        check(wr_en_o, we, "write enable");
        check(flags_we_o, fwe, "flag enable");
        if (we) check(wr_reg_o, rd, "dest");
        if (we) check(wr_data_o, dat, "data");
        if (fwe) check(program_status_flags_o, fl, "flags");
    endtask
    // ==========================================
    // scenarios
    task automatic t_rotate_reg();
        load(4'h0, 32'h80000001, 4'h3);
        load(4'h1, 32'h00000104, 4'h3);
        exec(0, 32'h41C8, 1, 0, 1, 4'h0, 32'h18000000, 1, 4'h1);
        exec(0, 32'h41C8, 1, 1, 1, 4'h0, 32'h01800000, 0, 4'h0);
        load(4'h1, 32'h00000F00, 4'h2);
        exec(0, 32'h41C8, 1, 0, 1, 4'h0, 32'h01800000, 1, 4'h2);
        load(4'h2, 32'h000000F1, 4'h0);
        load(4'h5, 32'h00000001, 4'h0);
        exec(1, 32'hFA62F405, 1, 0, 1, 4'h4, 32'h80000078, 0, 4'h0);
        exec(1, 32'hFA72F405, 1, 0, 1, 4'h4, 32'h80000078, 1, 4'hA);
    endtask
    task automatic t_rotate_imm();
        load(4'h2, 32'h00000003, 4'h2);
        exec(1, 32'hEA5F0632, 1, 0, 1, 4'h6, 32'h80000001, 1, 4'hA);
        exec(1, 32'hEA5F2632, 1, 0, 1, 4'h6, 32'h03000000, 1, 4'h0);
        exec(1, 32'hEA5F76F2, 1, 0, 1, 4'h6, 32'h00000006, 1, 4'h0);
    endtask
    task automatic t_reverse_sub();
        load(4'h3, 32'h00000005, 4'h0);
        exec(0, 32'h425F, 1, 0, 1, 4'h7, 32'hFFFFFFFB, 1, 4'h8);
        exec(1, 32'hF1D30710, 1, 0, 1, 4'h7, 32'h0000000B, 1, 4'h2);
        load(4'h3, 32'h80000000, 4'h0);
        exec(0, 32'h425F, 1, 0, 1, 4'h7, 32'h80000000, 1, 4'h9);
        exec(0, 32'h425F, 1, 1, 1, 4'h7, 32'h80000000, 0, 4'h0);
    endtask
    task automatic t_refused();
        exec(0, 32'h41C8, 0, 0, 0, 4'h0, 32'h0, 0, 4'h0);
        check(recognised_o, 1'b1, "recognised");
        check(unpredictable_o, 1'b0, "predictable");
        exec(1, 32'hEA5F0D32, 1, 0, 0, 4'h0, 32'h0, 0, 4'h0);
        check(unpredictable_o, 1'b1, "unpredictable");
        exec(1, 32'hF1DD0710, 1, 0, 0, 4'h0, 32'h0, 0, 4'h0);
        check(unpredictable_o, 1'b1, "unpredictable");
        exec(0, 32'h4000, 1, 0, 0, 4'h0, 32'h0, 0, 4'h0);
        check(recognised_o, 1'b0, "unrecognised");
    endtask
    task automatic t_reset();
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        @(posedge sys_clk_i);
        #1;
        check(wr_en_o, 1'b0, "reset write enable");
        check(flags_we_o, 1'b0, "reset flag enable");
        check(wr_data_o, 32'h00000000, "reset data");
        check(program_status_flags_o, {28'h0000000, FLAGS_RST}, "reset flags");
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        exec(0, 32'h425F, 1, 0, 1, 4'h7, 32'h80000000, 1, 4'h9);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_rotate_reg();
        t_rotate_imm();
        t_reverse_sub();
        t_refused();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
